// ### logic/clock_reset_sequencer.sv
`timescale 1ns/1ps
`include "clock_reset_defs.svh"
// Contract
// R1 - slow select 0 gives cpu clock = osc clock; 1 gives osc clock / 32
// R2 - clock-out enable drives main clock to pin, else pin free for gpio
// R3 - any reset clears clock-out and slow bits; software writes reserved bits zero
// R4 - trim register resets to ff, lowest frequency; 00 is highest
// R5 - software should load trim after reset, searching from 80
// R6 - external, low-supply and watchdog sources act on pin, low during delay
// R7 - after sequence the vector is fetched from fffe-ffff
// R8 - every reset runs active phase, stabilisation delay, then vector fetch
// R9 - delay is 256 cycles for rc or external clock, 4096 for crystal
// R10 - vector fetch phase lasts exactly two cycles
// R11 - with pll enabled an extra start-up delay follows the reset delay
// R12 - external reset detected asynchronously; driver holds minimum pulse width
// R13 - crystal oscillator keeps running through reset
// R14 - watchdog underflow drives pin low for minimum width, then sequence
// R15 - low-supply reset holds the pin low while active
// R16 - low-supply detector optional, threshold low, medium or high by config
// R17 - without multi-oscillator the external clock comes from a port pin
// R18 - watchdog flag set on watchdog reset, cleared by writing zero or low-supply
// R19 - low-supply flag set on low-supply reset, cleared by read only
// R20 - slow/normal switch only at divider boundary, no short cpu clocks
module clock_reset_sequencer import clock_reset_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter int DELAY_SHORT = `DELAY_SHORT_CYC,
	parameter int DELAY_LONG = `DELAY_LONG_CYC,
	parameter int PLL_CYC = (`PLL_STARTUP_NS + `HCLK_PERIOD_NS - 1) / `HCLK_PERIOD_NS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] clk_source,
	input wire logic pll_enable,
	input wire logic lvd_enable,
	input wire logic [1:0] lvd_threshold_cfg,
	input wire logic mo_used,
	input wire logic supply_low,
	input wire logic wdg_underflow,
	input wire logic rst_pin_in_n,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	output logic cpu_clk_en,
	output logic cpu_rst_n,
	output logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic clock_out_enable,
	output logic clock_out_gpio_free,
	output logic [7:0] rc_trim_code,
	output logic osc_enable,
	output logic [1:0] lvd_level_sel,
	output logic lvd_detector_on,
	output logic ext_clk_from_port
);
	localparam int WDG_CYC = (`WDG_PULSE_NS + `HCLK_PERIOD_NS - 1) / `HCLK_PERIOD_NS;
	localparam int CNT_W = $clog2(DELAY_LONG + 1);
	localparam int PLL_W = $clog2(PLL_CYC + 1);
	localparam int WDG_W = $clog2(WDG_CYC + 1);

	seq_state_t state;
	logic [CNT_W-1:0] delay_cnt;
	logic [CNT_W-1:0] delay_target;
	logic [PLL_W-1:0] pll_cnt;
	logic [WDG_W-1:0] wdg_cnt;
	logic fetch_cnt;
	logic ext_hold;
	logic ext_s1;
	logic ext_s2;
	logic [2:0] oe_hist;
	logic ext_low;
	logic lvd_act;
	logic src_any;
	logic in_reset;
	logic slow_mode_select;
	logic watchdog_reset_flag;
	logic low_supply_reset_flag;
	logic acc;
	logic wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	logic rd_integrity;
	logic [31:0] next_rdata;

	clk_div_if dv_if ();

	cpu_clk_div #(.DIV(`SLOW_DIV)) u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.dv(dv_if.div)
	);

	// ==========================================
	// Reset sources
	// R12 - async capture
	always_ff @(posedge hclk or negedge rst_pin_in_n) begin
		if (!rst_pin_in_n) begin
			ext_hold <= 1'b1;
		end else begin
			ext_hold <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			oe_hist <= 3'h7;
		end else begin
			ext_s1 <= ext_hold;
			ext_s2 <= ext_s1;
			oe_hist <= {oe_hist[1:0], rst_pin_oe};
		end
	end

	// Our own pull-down echoes back through the pin; ignore it until the echo has drained
	assign ext_low = ext_s2 && !rst_pin_oe && (oe_hist == 3'h0);
	// R16 - detector only counts when enabled
	assign lvd_act = lvd_enable && supply_low;
	assign src_any = ext_low || lvd_act || wdg_underflow;
	assign in_reset = (state != S_RUN);
	assign delay_target = (clk_source == SRC_XTAL) ? CNT_W'(DELAY_LONG) : CNT_W'(DELAY_SHORT);

	// R14 - minimum watchdog output pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdg_cnt <= '0;
		end else if (wdg_underflow) begin
			wdg_cnt <= WDG_W'(WDG_CYC);
		end else if (wdg_cnt != '0) begin
			wdg_cnt <= WDG_W'(wdg_cnt - 1'b1);
		end
	end

	// ==========================================
	// Sequence
	// R8 - active, delay, fetch in order
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= S_ACTIVE;
		end else if (src_any) begin
			state <= S_ACTIVE;
		end else begin
			unique case (state)
				S_ACTIVE: begin
					if (wdg_cnt == '0) begin
						state <= S_DELAY;
					end
				end
				// R9 - source dependent delay
				S_DELAY: begin
					if (delay_cnt == CNT_W'(delay_target - 1'b1)) begin
						// R11 - pll start-up on top
						state <= pll_enable ? S_PLL : S_FETCH;
					end
				end
				S_PLL: begin
					if (pll_cnt == PLL_W'(PLL_CYC - 1)) begin
						state <= S_FETCH;
					end
				end
				// R10 - two fetch cycles
				S_FETCH: begin
					if (fetch_cnt) begin
						state <= S_RUN;
					end
				end
				S_RUN: begin
					state <= S_RUN;
				end
				default: begin
					state <= S_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			delay_cnt <= '0;
		end else if (state == S_DELAY && !src_any) begin
			delay_cnt <= CNT_W'(delay_cnt + 1'b1);
		end else begin
			delay_cnt <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_cnt <= '0;
		end else if (state == S_PLL && !src_any) begin
			pll_cnt <= PLL_W'(pll_cnt + 1'b1);
		end else begin
			pll_cnt <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch_cnt <= 1'b0;
		end else begin
			fetch_cnt <= (state == S_FETCH) && !fetch_cnt && !src_any;
		end
	end

	// R6 - pin low through active drive and delay
	// R15 - held while supply is low
	assign rst_pin_oe = (state == S_ACTIVE && (lvd_act || wdg_cnt != '0)) ||
		state == S_DELAY || state == S_PLL;
	assign rst_pin_out = 1'b0;
	assign cpu_rst_n = (state == S_FETCH) || (state == S_RUN);
	assign vector_fetch = (state == S_FETCH);
	// R7 - fixed vector word
	assign vector_addr = `RESET_VECTOR_ADDR | {15'h0, fetch_cnt};

	// ==========================================
	// Clock control
	// R3 - any reset clears the mode bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_out_enable <= 1'((`RST_MAIN_CLOCK_CTRL_STATUS >> `BIT_CLOCK_OUT_ENABLE) & 8'h01);
			slow_mode_select <= 1'((`RST_MAIN_CLOCK_CTRL_STATUS >> `BIT_SLOW_MODE_SELECT) & 8'h01);
		end else if (in_reset) begin
			clock_out_enable <= 1'b0;
			slow_mode_select <= 1'b0;
		end else if (wr_pend && wr_addr == ADDR_W'(`OFS_MAIN_CLOCK_CTRL_STATUS)) begin
			clock_out_enable <= hwdata[`BIT_CLOCK_OUT_ENABLE];
			slow_mode_select <= hwdata[`BIT_SLOW_MODE_SELECT];
		end
	end

	// R4 - trim back to lowest frequency on any reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_trim_code <= `RST_RC_OSC_TRIM;
		end else if (in_reset) begin
			rc_trim_code <= `RST_RC_OSC_TRIM;
		end else if (wr_pend && wr_addr == ADDR_W'(`OFS_RC_OSC_TRIM)) begin
			rc_trim_code <= hwdata[7:0];
		end
	end

	// R1 - divider does the division
	assign dv_if.slow_req = slow_mode_select;
	assign cpu_clk_en = dv_if.cpu_clk_en;
	// R2 - pad mux select
	assign clock_out_gpio_free = !clock_out_enable;
	// R13 - oscillator never stopped by reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_enable <= 1'b1;
		end else begin
			osc_enable <= 1'b1;
		end
	end
	// R16 - threshold passed to detector
	assign lvd_detector_on = lvd_enable;
	assign lvd_level_sel = lvd_enable ? lvd_threshold_cfg : 2'h0;
	// R17 - port pin clock when no multi-oscillator
	assign ext_clk_from_port = !mo_used;

	// ==========================================
	// Reset cause flags
	// R18 - set wins over any clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_reset_flag <= 1'b0;
		end else if (wdg_underflow) begin
			watchdog_reset_flag <= 1'b1;
		end else if (lvd_act) begin
			watchdog_reset_flag <= 1'b0;
		end else if (wr_pend && wr_addr == ADDR_W'(`OFS_INTEGRITY_CTRL_STATUS) &&
			!hwdata[`BIT_WATCHDOG_RESET_FLAG]) begin
			watchdog_reset_flag <= 1'b0;
		end
	end

	// R19 - cleared only by reading
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_supply_reset_flag <= 1'b0;
		end else if (lvd_act) begin
			low_supply_reset_flag <= 1'b1;
		end else if (rd_integrity) begin
			low_supply_reset_flag <= 1'b0;
		end
	end

	// ==========================================
	// Bus slave
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign acc = hsel && hready && htrans[1];
	assign rd_integrity = acc && !hwrite && haddr == ADDR_W'(`OFS_INTEGRITY_CTRL_STATUS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else begin
			wr_pend <= acc && hwrite;
			wr_addr <= haddr;
		end
	end

	always_comb begin
		next_rdata = 32'h0;
		if (haddr == ADDR_W'(`OFS_MAIN_CLOCK_CTRL_STATUS)) begin
			next_rdata[`BIT_CLOCK_OUT_ENABLE] = clock_out_enable;
			next_rdata[`BIT_SLOW_MODE_SELECT] = slow_mode_select;
		end else if (haddr == ADDR_W'(`OFS_RC_OSC_TRIM)) begin
			next_rdata[7:0] = rc_trim_code;
		end else if (haddr == ADDR_W'(`OFS_INTEGRITY_CTRL_STATUS)) begin
			next_rdata[`BIT_WATCHDOG_RESET_FLAG] = watchdog_reset_flag;
			next_rdata[`BIT_LOW_SUPPLY_RESET_FLAG] = low_supply_reset_flag;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (acc && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ==========================================
	// Checks
	sequence fetch_two;
		vector_fetch [*2] ##1 !vector_fetch;
	endsequence

	chk_pin_delay_low: assert property (@(posedge hclk) disable iff (!hresetn) // R6
		(state == S_DELAY) |-> rst_pin_oe && !rst_pin_out)
		else $error("pin released during delay");
	chk_phase_order: assert property (@(posedge hclk) disable iff (!hresetn) // R8
		(state == S_DELAY) |=> state inside {S_ACTIVE, S_DELAY, S_PLL, S_FETCH})
		else $error("delay left to wrong phase");
	chk_delay_end: assert property (@(posedge hclk) disable iff (!hresetn) // R9
		(state == S_DELAY && !src_any && delay_cnt == CNT_W'(delay_target - 1'b1)) |=> state != S_DELAY)
		else $error("delay overran");
	chk_delay_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R9
		(state == S_DELAY && !src_any && delay_cnt < CNT_W'(delay_target - 1'b1)) |=> state == S_DELAY)
		else $error("delay cut short");
	chk_fetch_two: assert property (@(posedge hclk) disable iff (!hresetn) // R10
		($rose(vector_fetch) && !src_any ##1 !src_any) |-> $past(vector_fetch) ##0 vector_fetch ##1 !vector_fetch)
		else $error("fetch phase not two cycles");
	chk_fetch_vector: assert property (@(posedge hclk) disable iff (!hresetn) // R7
		$rose(vector_fetch) |-> vector_addr == `RESET_VECTOR_ADDR)
		else $error("wrong reset vector");
	chk_pll_extra: assert property (@(posedge hclk) disable iff (!hresetn) // R11
		(state == S_FETCH && $past(state) != S_FETCH && pll_enable) |-> $past(state) == S_PLL)
		else $error("pll start-up skipped");
	chk_mode_cleared: assert property (@(posedge hclk) disable iff (!hresetn) // R3
		(in_reset && !$past(wr_pend)) |=> !clock_out_enable && !slow_mode_select)
		else $error("mode bits kept through reset");
	chk_trim_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R4
		in_reset |=> rc_trim_code == 8'hff)
		else $error("trim not restored");
	chk_wdg_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // R14
		wdg_underflow |=> rst_pin_oe [*8])
		else $error("watchdog pin pulse too short");
	chk_lvd_pin: assert property (@(posedge hclk) disable iff (!hresetn) // R15
		lvd_act |-> (rst_pin_oe || state != S_ACTIVE) ##1 (rst_pin_oe || !lvd_act))
		else $error("pin not held on low supply");
	chk_wdg_flag: assert property (@(posedge hclk) disable iff (!hresetn) // R18
		wdg_underflow |=> watchdog_reset_flag)
		else $error("watchdog flag not set");
	chk_lvd_flag: assert property (@(posedge hclk) disable iff (!hresetn) // R19
		(low_supply_reset_flag && !rd_integrity) |=> low_supply_reset_flag)
		else $error("low supply flag lost without read");
endmodule : clock_reset_sequencer

// ### logic/cpu_clk_div.sv
`timescale 1ns/1ps
`include "clock_reset_defs.svh"
module cpu_clk_div import clock_reset_pkg::*; #(
	parameter int DIV = `SLOW_DIV
) (
	input wire logic hclk,
	input wire logic hresetn,
	clk_div_if.div dv
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;
	logic boundary;

	assign boundary = (cnt == LAST);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
		end else begin
			cnt <= CW'(cnt + 1'b1);
		end
	end

	// R20 - switch at wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dv.slow_active <= 1'b0;
		end else if (boundary) begin
			dv.slow_active <= dv.slow_req;
		end
	end

	// R1 - divide by DIV
	assign dv.cpu_clk_en = dv.slow_active ? boundary : 1'b1;

	// ==========================================
	// Checks
	chk_slow_gap: assert property (@(posedge hclk) disable iff (!hresetn) // R1
		(dv.slow_active && dv.cpu_clk_en && dv.slow_req) |=> !dv.cpu_clk_en [*8])
		else $error("slow mode enable pulse too close");
	chk_normal_every: assert property (@(posedge hclk) disable iff (!hresetn) // R1
		!dv.slow_active |-> dv.cpu_clk_en)
		else $error("normal mode lost a cpu clock");
	chk_switch_boundary: assert property (@(posedge hclk) disable iff (!hresetn) // R20
		$changed(dv.slow_active) |-> $past(cnt) == LAST)
		else $error("clock mode switched off boundary");
endmodule : cpu_clk_div

// ### pkg/clk_div_if.sv
`timescale 1ns/1ps
interface clk_div_if;
	logic slow_req;
	logic slow_active;
	logic cpu_clk_en;

	modport ctrl (output slow_req, input slow_active, input cpu_clk_en);
	modport div (input slow_req, output slow_active, output cpu_clk_en);
endinterface : clk_div_if

// ### pkg/clock_reset_defs.svh
`ifndef CLOCK_RESET_DEFS_SVH
`define CLOCK_RESET_DEFS_SVH

// ==========================================
// Register byte offsets
`define OFS_MAIN_CLOCK_CTRL_STATUS 8'h00
`define OFS_RC_OSC_TRIM 8'h04
`define OFS_INTEGRITY_CTRL_STATUS 8'h08

// ==========================================
// Field positions
`define BIT_SLOW_MODE_SELECT 0
`define BIT_CLOCK_OUT_ENABLE 1
`define BIT_LOW_SUPPLY_RESET_FLAG 2
`define BIT_WATCHDOG_RESET_FLAG 4

// ==========================================
// Reset values
`define RST_MAIN_CLOCK_CTRL_STATUS 8'h00
`define RST_RC_OSC_TRIM 8'hff

// ==========================================
// Timing
`define HCLK_PERIOD_NS 5
`define SLOW_DIV 32
`define DELAY_SHORT_CYC 256
`define DELAY_LONG_CYC 4096
`define FETCH_CYC 2
`define WDG_PULSE_NS 100
`define PLL_STARTUP_NS 1000
`define RESET_VECTOR_ADDR 16'hfffe

`endif

// ### pkg/clock_reset_pkg.sv
package clock_reset_pkg;
	typedef enum logic [2:0] {
		S_ACTIVE = 3'b000,
		S_DELAY = 3'b001,
		S_PLL = 3'b010,
		S_FETCH = 3'b011,
		S_RUN = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		SRC_RC = 2'b00,
		SRC_EXT = 2'b01,
		SRC_XTAL = 2'b10
	} clk_src_t;
endpackage : clock_reset_pkg

// ### test/reset_line_model.sv
`timescale 1ns/1ps
module reset_line_model (
	input wire logic hclk,
	input wire logic rst_pin_oe,
	input wire logic rst_pin_out,
	output logic rst_pin_in_n
);
	logic ext_pull = 1'b0;
	// ==========================================
	// Wire level
	// open drain with pull-up
	assign rst_pin_in_n = (rst_pin_oe ? rst_pin_out : 1'b1) & !ext_pull;
	task automatic pull(input int n);
		@(posedge hclk);
		ext_pull <= 1'b1;
		repeat (n) @(posedge hclk);
		ext_pull <= 1'b0;
	endtask : pull
endmodule : reset_line_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench import clock_reset_pkg::*;;
	localparam int DS = 8;
	localparam int DL = 16;
	localparam int PC = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] clk_source = 2'h0;
	logic pll_enable = 1'b0;
	logic lvd_enable = 1'b0;
	logic [1:0] lvd_threshold_cfg = 2'h2;
	logic mo_used = 1'b1;
	logic supply_low = 1'b0;
	logic wdg_underflow = 1'b0;
	logic hreadyout, hresp, rst_pin_in_n, rst_pin_out, rst_pin_oe, cpu_clk_en, cpu_rst_n;
	logic vector_fetch, clock_out_enable, clock_out_gpio_free, osc_enable, lvd_detector_on, ext_clk_from_port;
	logic [31:0] hrdata;
	logic [15:0] vector_addr;
	logic [7:0] rc_trim_code;
	logic [1:0] lvd_level_sel;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	always #2.5 hclk = ~hclk;
	clock_reset_sequencer #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .PLL_CYC(PC)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .clk_source(clk_source), .pll_enable(pll_enable), .lvd_enable(lvd_enable),
		.lvd_threshold_cfg(lvd_threshold_cfg), .mo_used(mo_used), .supply_low(supply_low),
		.wdg_underflow(wdg_underflow), .rst_pin_in_n(rst_pin_in_n), .rst_pin_out(rst_pin_out),
		.rst_pin_oe(rst_pin_oe), .cpu_clk_en(cpu_clk_en), .cpu_rst_n(cpu_rst_n), .vector_fetch(vector_fetch),
		.vector_addr(vector_addr), .clock_out_enable(clock_out_enable), .clock_out_gpio_free(clock_out_gpio_free),
		.rc_trim_code(rc_trim_code), .osc_enable(osc_enable), .lvd_level_sel(lvd_level_sel),
		.lvd_detector_on(lvd_detector_on), .ext_clk_from_port(ext_clk_from_port)
	);
	reset_line_model line (.hclk(hclk), .rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out),
		.rst_pin_in_n(rst_pin_in_n));
	// ==========================================
	// Helpers
	task automatic report_and_stop();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		#1;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		ahb(1'b0, a, 32'h0, v);
	endtask : rd
	// Follows a running sequence until the vector fetch has ended
	task automatic run_seq(output int t, output int oe);
		int vf;
		vf = 0;
		t = 0;
		oe = 0;
		for (int i = 0; i < 2000; i++) begin
			@(posedge hclk);
			#1;
			if (i == 2) check(osc_enable, 1'b1);
			if (rst_pin_oe === 1'b1) oe++;
			if (cpu_rst_n !== 1'b1) t++;
			if (vector_fetch === 1'b1) begin
				check(vector_addr, vf == 0 ? 16'hfffe : 16'hffff);
				vf++;
			end else if (vf > 0) break;
		end
		check(vf, 2);
	endtask : run_seq
	task automatic cold(input clk_src_t s, input logic p, output int t, output int oe);
		@(posedge hclk);
		clk_source <= s;
		pll_enable <= p;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		run_seq(t, oe);
	endtask : cold
	task automatic count_en(output int n);
		n = 0;
		repeat (64) begin
			@(posedge hclk);
			#1;
			if (cpu_clk_en === 1'b1) n++;
		end
	endtask : count_en
	// ==========================================
	// Scenarios
	task automatic t_seq();
		int t_rc, t_x, oe;
		logic [31:0] v;
		cold(SRC_RC, 1'b0, t_rc, oe);
		check(oe >= DS, 1'b1);
		cold(SRC_EXT, 1'b0, t_x, oe);
		check(t_x, t_rc);
		cold(SRC_XTAL, 1'b0, t_x, oe);
		check(t_x - t_rc, DL - DS);
		cold(SRC_RC, 1'b1, t_x, oe);
		check(t_x - t_rc, PC);
		cold(SRC_RC, 1'b0, t_x, oe);
		rd(8'h00, v);
		check(v, 32'h0);
		rd(8'h04, v);
		check(v, 32'hff);
		@(posedge hclk);
		mo_used <= 1'b0;
		rd(8'h0c, v);
		check(v, 32'h0);
		check(ext_clk_from_port, 1'b1);
		$display("t_seq done");
	endtask : t_seq
	task automatic t_regs();
		logic [31:0] v;
		int n;
		wr(8'h00, 32'h2);
		check(clock_out_enable, 1'b1);
		check(clock_out_gpio_free, 1'b0);
		count_en(n);
		check(n, 64);
		wr(8'h00, 32'h1);
		check(clock_out_gpio_free, 1'b1);
		repeat (40) @(posedge hclk);
		count_en(n);
		check(n, 64 / 32);
		rd(8'h00, v);
		check(v, 32'h1);
		wr(8'h04, 32'h80);
		check(rc_trim_code, 8'h80);
		wr(8'h0c, 32'hffff_ffff);
		rd(8'h0c, v);
		check(v, 32'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_wdg();
		logic [31:0] v;
		int n, t, oe;
		wr(8'h00, 32'h3);
		@(posedge hclk);
		wdg_underflow <= 1'b1;
		@(posedge hclk);
		wdg_underflow <= 1'b0;
		n = 0;
		repeat (20) begin
			#1;
			if (rst_pin_oe === 1'b1) n++;
			@(posedge hclk);
		end
		check(n, 20);
		run_seq(t, oe);
		rd(8'h08, v);
		check(v & 32'h14, 32'h10);
		rd(8'h00, v);
		check(v, 32'h0);
		check(rc_trim_code, 8'hff);
		$display("t_wdg done");
	endtask : t_wdg
	task automatic t_lvd_ext();
		logic [31:0] v;
		int n, t, oe;
		check(lvd_level_sel, 2'h0);
		@(posedge hclk);
		lvd_enable <= 1'b1;
		@(posedge hclk);
		#1;
		check(lvd_level_sel, 2'h2);
		check(lvd_detector_on, 1'b1);
		@(posedge hclk);
		supply_low <= 1'b1;
		repeat (3) @(posedge hclk);
		count_en(n);
		check(n, 64);
		n = 0;
		repeat (30) begin
			@(posedge hclk);
			#1;
			if (rst_pin_oe === 1'b1) n++;
		end
		check(n, 30);
		@(posedge hclk);
		supply_low <= 1'b0;
		run_seq(t, oe);
		line.pull(8);
		#1;
		check(cpu_rst_n, 1'b0);
		run_seq(t, oe);
		rd(8'h08, v);
		check(v & 32'h14, 32'h04);
		rd(8'h08, v);
		check(v & 32'h14, 32'h00);
		wr(8'h08, 32'h0);
		$display("t_lvd_ext done");
	endtask : t_lvd_ext
	initial begin
		t_seq();
		t_regs();
		t_wdg();
		t_lvd_ext();
		report_and_stop();
	end
endmodule : testbench
